// ### logic/device_setup_block.sv
// Purpose: Device setup register with alert flags and serial output control
// Assumes: AXI4-Lite master on i_clk_sys; link clock sampled as a plain input
// Notes: Rules carried by this block are listed below
// Function
// - Setup register at 0x0020 holds eight read/write bits resetting to 0x10.
// - Bit 7 at 0 lets hysteresis clear the alert flags, at 1 disables that.
// - Reading the alert status register clears the flags it returned.
// - With bit 6 at 0 the data output holds its last value until the next MSB.
// - With bit 6 at 1 in conversion mode (bit 2 at 1) the data output shows busy at frame start and end.
// - Bit 5 at 1 appends status bits to each result, at 0 omits them.
// - Bit 4 enables the regulator and resets to 1.
// - Clearing bit 4 while the regulator feeds the core powers the core down.
// - Bit 2 picks register mode at 0 and conversion mode at 1, set by writing 1.
// - The register mode command clears bit 2.
// - Bit 1 picks two-cycle command mode at 0 and single-cycle at 1.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module device_setup_block (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Conversion results from the core, same clock
  input wire logic i_result_valid,
  input wire logic [2:0] i_result_chan,
  input wire logic [15:0] i_result_data,
  input wire logic i_above_upper,
  input wire logic i_below_lower,
  input wire logic i_within_hyst,
  input wire logic i_conv_busy,
  // Power strap, high when the core is fed externally
  input wire logic i_ext_core_supply,
  // Serial link pins
  input wire setup_pkg::link_in_s i_link,
  output logic o_sdo,
  // Setup outputs
  output logic o_regulator_enable,
  output logic o_core_powered,
  output logic o_conversion_mode,
  output logic o_command_cycle_select,
  output logic o_status_append,
  output logic o_alert_mode,
  // Interrupt
  output logic o_irq
);
  setup_pkg::setup_s setup;
  setup_pkg::link_state_e lk_state;
  logic [7:0] upper_alert_flag, lower_alert_flag, aw_addr;
  logic [2:0] irq_stat, irq_mask, ev, link_sync;
  logic [31:0] w_data, next_rdata;
  logic [15:0] alert_clr_mask;
  logic [3:0] w_strb;
  logic [4:0] bits_left, cmd_cnt;
  logic [setup_pkg::FRAME_W-1:0] shreg;
  logic [setup_pkg::CMD_W-1:0] cmd_shift;
  logic core_dead, aw_held, w_held, do_write, rd_take, next_rerr, alert_rd_clr, regcmd_seen;
  logic lk_clk, lk_cs_n, lk_sdi, lk_clk_d, lk_cs_d, lk_rise, lk_fall, frame_start, frame_end;
  // Write channel handshake: address and data taken in either order
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign do_write = aw_held && w_held && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign rd_take = i_arvalid && o_arready;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= setup_pkg::RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      case (aw_addr)
        setup_pkg::ADDR_SETUP, setup_pkg::ADDR_ALERT, setup_pkg::ADDR_IRQ_STAT,
        setup_pkg::ADDR_IRQ_MASK, setup_pkg::ADDR_LINK_STAT: begin
          o_bresp <= setup_pkg::RESP_OKAY;
        end
        default: begin
          o_bresp <= setup_pkg::RESP_SLVERR;
        end
      endcase
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // core power loss
  // Once the regulator is switched off while it feeds the core, the core stays down until reset
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      core_dead <= 1'b0;
    end else if (!setup.regulator_enable && !i_ext_core_supply) begin
      core_dead <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      setup <= setup_pkg::SETUP_RESET;
    end else if (core_dead) begin
      setup <= setup_pkg::SETUP_RESET & 8'hEF;
    end else if (do_write && aw_addr == setup_pkg::ADDR_SETUP && w_strb[0]) begin
      setup <= w_data[7:0];
    end else if (regcmd_seen) begin
      setup.interface_mode <= 1'b0;
    end
  end

  assign alert_rd_clr = rd_take && i_araddr == setup_pkg::ADDR_ALERT;
  assign alert_clr_mask = alert_rd_clr ? {upper_alert_flag, lower_alert_flag} : 16'h0000;

  // Alert flags; a new event in the clearing cycle wins
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || core_dead) begin
      upper_alert_flag <= 8'h00;
      lower_alert_flag <= 8'h00;
    end else begin
      for (int c = 0; c < 8; c++) begin
        logic hit, up_set, lo_set, hys_clr;
        hit = i_result_valid && i_result_chan == c[2:0];
        up_set = hit && i_above_upper;
        lo_set = hit && i_below_lower;
        // hysteresis only when bit 7 is low
        hys_clr = hit && i_within_hyst && !setup.alert_mode;
        if (up_set) begin
          upper_alert_flag[c] <= 1'b1;
        end else if (alert_clr_mask[8+c] || hys_clr) begin
          upper_alert_flag[c] <= 1'b0;
        end
        if (lo_set) begin
          lower_alert_flag[c] <= 1'b1;
        end else if (alert_clr_mask[c] || hys_clr) begin
          lower_alert_flag[c] <= 1'b0;
        end
      end
    end
  end

  // Interrupt events
  assign ev[setup_pkg::IRQ_ALERT] = i_result_valid && !core_dead && (i_above_upper || i_below_lower);
  assign ev[setup_pkg::IRQ_FRAME] = frame_end;
  assign ev[setup_pkg::IRQ_REGCMD] = regcmd_seen;

  // Sticky status, write one to clear; set beats clear
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      irq_stat <= setup_pkg::IRQ_RESET;
      irq_mask <= setup_pkg::IRQ_RESET;
    end else begin
      if (do_write && aw_addr == setup_pkg::ADDR_IRQ_STAT && w_strb[0]) begin
        irq_stat <= (irq_stat & ~w_data[2:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (do_write && aw_addr == setup_pkg::ADDR_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[2:0];
      end
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    case (i_araddr)
      setup_pkg::ADDR_SETUP: begin
        next_rdata[7:0] = setup;
      end
      setup_pkg::ADDR_ALERT: begin
        next_rdata[15:0] = {upper_alert_flag, lower_alert_flag};
      end
      setup_pkg::ADDR_IRQ_STAT: begin
        next_rdata[2:0] = irq_stat;
      end
      setup_pkg::ADDR_IRQ_MASK: begin
        next_rdata[2:0] = irq_mask;
      end
      setup_pkg::ADDR_LINK_STAT: begin
        next_rdata[4:0] = {core_dead, lk_state, o_sdo, lk_cs_n};
      end
      default: begin
        next_rerr = 1'b1;
      end
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= setup_pkg::RESP_OKAY;
    end else if (rd_take) begin
      o_rvalid <= 1'b1;
      o_rdata <= next_rdata;
      o_rresp <= next_rerr ? setup_pkg::RESP_SLVERR : setup_pkg::RESP_OKAY;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Link pins cross into the system clock; clock and select go in inverted so reset reads them idle high
  pin_sync3 #(.W(3)) u_link_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async({~i_link.clk, ~i_link.cs_n, i_link.sdi}),
    .o_level(link_sync)
  );
  assign lk_clk = ~link_sync[2];
  assign lk_cs_n = ~link_sync[1];
  assign lk_sdi = link_sync[0];
  // Edge finding on the filtered levels; history starts at the idle level, so no false frame after reset
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lk_clk_d <= 1'b1;
      lk_cs_d <= 1'b1;
    end else begin
      lk_clk_d <= lk_clk;
      lk_cs_d <= lk_cs_n;
    end
  end
  assign lk_rise = lk_clk && !lk_clk_d && !lk_cs_n;
  assign lk_fall = !lk_clk && lk_clk_d && !lk_cs_n;
  assign frame_start = !lk_cs_n && lk_cs_d;
  assign frame_end = lk_cs_n && !lk_cs_d;

  // Conversion frame shifter: MSB appears at the first falling link edge
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lk_state <= setup_pkg::LK_IDLE;
      shreg <= '0;
      bits_left <= setup_pkg::BITCNT_RESET;
    end else begin
      case (lk_state)
        setup_pkg::LK_IDLE: begin
          if (frame_start && setup.interface_mode && !core_dead) begin
            lk_state <= setup_pkg::LK_SHIFT;
            if (setup.status_append) begin
              shreg <= {i_result_data, i_result_chan, |{upper_alert_flag, lower_alert_flag}};
              bits_left <= 5'(setup_pkg::FRAME_W);
            end else begin
              shreg <= {i_result_data, {setup_pkg::STATUS_W{1'b0}}};
              bits_left <= 5'(setup_pkg::RESULT_W);
            end
          end
        end
        setup_pkg::LK_SHIFT: begin
          if (frame_end) begin
            lk_state <= setup_pkg::LK_IDLE;
          end else if (lk_fall) begin
            shreg <= {shreg[setup_pkg::FRAME_W-2:0], 1'b0};
            bits_left <= bits_left - 5'h01;
            if (bits_left == 5'h01) begin
              lk_state <= setup_pkg::LK_TAIL;
            end
          end
        end
        setup_pkg::LK_TAIL: begin
          if (frame_end) begin
            lk_state <= setup_pkg::LK_IDLE;
          end
        end
        default: begin
          lk_state <= setup_pkg::LK_IDLE;
        end
      endcase
    end
  end
  // Serial data output; the last bit stands through the tail so the host can still sample it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sdo <= 1'b0;
    end else if (lk_state == setup_pkg::LK_SHIFT && lk_fall) begin
      o_sdo <= shreg[setup_pkg::FRAME_W-1];
    end else if (setup.output_idle_behaviour && setup.interface_mode && !core_dead
                 && (lk_state == setup_pkg::LK_IDLE || bits_left == 5'(setup_pkg::FRAME_W)
                 || (bits_left == 5'(setup_pkg::RESULT_W) && !setup.status_append))) begin
      o_sdo <= i_conv_busy;
    end
    // otherwise the last value is held
  end

  // Command capture: first bits of each frame on rising link edges
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cmd_cnt <= setup_pkg::BITCNT_RESET;
      cmd_shift <= '0;
      regcmd_seen <= 1'b0;
    end else begin
      regcmd_seen <= 1'b0;
      if (frame_start) begin
        cmd_cnt <= setup_pkg::BITCNT_RESET;
      end else if (lk_rise && cmd_cnt < 5'(setup_pkg::CMD_W)) begin
        cmd_shift <= {cmd_shift[setup_pkg::CMD_W-2:0], lk_sdi};
        cmd_cnt <= cmd_cnt + 5'h01;
      end
      if (frame_end && setup.interface_mode && cmd_cnt == 5'(setup_pkg::CMD_W)
          && cmd_shift == setup_pkg::CMD_REG_MODE) begin
        regcmd_seen <= 1'b1;
      end
    end
  end

  assign o_regulator_enable = setup.regulator_enable;
  assign o_core_powered = !core_dead;
  assign o_conversion_mode = setup.interface_mode;
  assign o_command_cycle_select = setup.command_cycle_select;
  assign o_status_append = setup.status_append;
  assign o_alert_mode = setup.alert_mode;
endmodule

// ### logic/setup_pkg.sv
// Purpose: Shared constants and types for the device setup register block
// Assumes: AXI4-Lite register access, 25 MHz system clock
// Notes: Byte addresses are word aligned
package setup_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_SETUP = 8'h20;
  localparam logic [7:0] ADDR_ALERT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
  localparam logic [7:0] ADDR_LINK_STAT = 8'h30;

  // Setup fields, bit 7 down to bit 0
  typedef struct packed {
    logic alert_mode;
    logic output_idle_behaviour;
    logic status_append;
    logic regulator_enable;
    logic rsv3;
    logic interface_mode;
    logic command_cycle_select;
    logic rsv0;
  } setup_s;
  localparam logic [7:0] SETUP_RESET = 8'h10;

  // Interrupt event bit positions
  localparam int IRQ_ALERT = 0;
  localparam int IRQ_FRAME = 1;
  localparam int IRQ_REGCMD = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Link framing
  localparam int RESULT_W = 16;
  localparam int STATUS_W = 4;
  localparam int FRAME_W = RESULT_W + STATUS_W;
  localparam int CMD_W = 5;
  localparam logic [4:0] CMD_REG_MODE = 5'h14;
  localparam logic [4:0] BITCNT_RESET = 5'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Link-side pin group from the far party
  typedef struct packed {
    logic clk;
    logic cs_n;
    logic sdi;
  } link_in_s;

  // Frame sequencing
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_SHIFT = 2'b01,
    LK_TAIL = 2'b11
  } link_state_e;
endpackage

// ### logic/pin_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to i_clk_sys
// Notes: Output changes only once stages two and three agree
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Raw and filtered levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // First stage feeds only the second; the filter reads stages two and three
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      o_level <= '0;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          o_level[i] <= s3[i];
        end
      end
    end
  end
endmodule

// ### dv/setup_props.sv
// Purpose: Port-level checks for the device setup block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Watches only the block's ports
`timescale 1ns/10ps
module setup_props (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Bus handshakes
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // Bus payloads
  input wire logic [1:0] o_bresp,
  input wire logic [1:0] o_rresp,
  input wire logic [7:0] i_araddr,
  input wire logic [31:0] o_rdata,
  // Setup outputs
  input wire logic o_regulator_enable,
  input wire logic o_core_powered,
  input wire logic o_conversion_mode,
  input wire logic o_command_cycle_select,
  input wire logic o_status_append,
  input wire logic o_alert_mode
);
  // Reset gates every property
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_reset_setup: assert property (
    $fell(i_rst) |-> o_regulator_enable && o_core_powered && !o_conversion_mode && !o_alert_mode)
    else $error("setup outputs wrong after reset");
  a_read_latency: assert property (
    i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  // Read data must match the outputs seen when the read was taken
  a_setup_read: assert property (
    i_arvalid && o_arready && i_araddr == setup_pkg::ADDR_SETUP |=> o_rdata[31:8] == 24'h0
    && o_rdata[7] == $past(o_alert_mode) && o_rdata[5] == $past(o_status_append)
    && o_rdata[4] == $past(o_regulator_enable) && o_rdata[2] == $past(o_conversion_mode)
    && o_rdata[1] == $past(o_command_cycle_select)) else $error("setup read mismatch");
  a_write_resp: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid) else $error("write answer late");
  a_bresp_hold: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp) && !o_awready) else $error("write answer dropped");
  a_unmapped_read: assert property (
    i_arvalid && o_arready && !(i_araddr inside {8'h20, 8'h24, 8'h28, 8'h2C, 8'h30})
    |=> o_rresp == setup_pkg::RESP_SLVERR && o_rdata == 32'h0) else $error("unmapped read answered");
  a_core_off: assert property (
    !o_core_powered |=> !o_core_powered && !o_regulator_enable && !o_conversion_mode)
    else $error("core came back without reset");
endmodule

bind device_setup_block setup_props i_setup_props (.i_clk_sys, .i_rst, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_bresp, .o_rresp,
  .i_araddr, .o_rdata, .o_regulator_enable, .o_core_powered, .o_conversion_mode, .o_command_cycle_select,
  .o_status_append, .o_alert_mode);

// ### dv/link_host_model.sv
// Purpose: Serial host that frames the link and captures data
// Assumes: 320 ns link clock, idle high, still between frames
// Notes: Pins move 7 ns after the system edge, at a fixed phase to it
`timescale 1ns/10ps
module link_host_model (
  // Link pins toward the device
  output setup_pkg::link_in_s o_link,
  // Serial data from the device
  input wire logic i_sdo
);
  // Deselected and quiet at start
  initial o_link = '{clk: 1'h1, cs_n: 1'h1, sdi: 1'h0};

  // One frame: command on first five bits, then a toggling filler
  task automatic frame(input int nb, input logic [4:0] cmd, output logic [19:0] got,
                       output logic pre, output logic post);
    got = 20'h0;
    #7 o_link.cs_n = 1'h0;
    #320 pre = i_sdo;
    for (int b = 0; b < nb; b++) begin
      o_link.clk = 1'h0;
      o_link.sdi = (b < 5) ? cmd[4 - b] : ~o_link.sdi;
      #160 o_link.clk = 1'h1;
      #160 got = {got[18:0], i_sdo};
    end
    // Close the frame first: busy or the held bit shows once the device has seen select high
    #320 o_link.cs_n = 1'h1;
    o_link.sdi = ~o_link.sdi;
    #320 post = i_sdo;
  endtask
endmodule

// ### dv/tb.sv
// Purpose: Self-checking bench for the device setup block
// Assumes: 25 MHz clock, bus tasks entered just after an edge
// Notes: Frames are run by the link host model
`timescale 1ns/10ps
module tb;
  logic i_clk_sys = 1'h0, i_rst = 1'h1;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, v;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0] i_wstrb = 4'hF;
  logic i_result_valid = 1'h0, i_above_upper = 1'h0, i_below_lower = 1'h0, i_within_hyst = 1'h0;
  logic [2:0] i_result_chan = 3'h0;
  logic [15:0] i_result_data = 16'hA5C3;
  logic i_conv_busy = 1'h0, i_ext_core_supply = 1'h1;
  wire setup_pkg::link_in_s i_link;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sdo, o_irq, o_regulator_enable;
  logic o_core_powered, o_conversion_mode, o_command_cycle_select, o_status_append, o_alert_mode;
  logic [1:0] o_bresp, o_rresp;
  logic [19:0] got;
  logic pre, post;
  int n_fail = 0, total_checks = 0;

  device_setup_block i_device_setup_block (.i_clk_sys, .i_rst, .i_awvalid, .o_awready, .i_awaddr,
    .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_result_valid, .i_result_chan, .i_result_data,
    .i_above_upper, .i_below_lower, .i_within_hyst, .i_conv_busy, .i_ext_core_supply, .i_link, .o_sdo,
    .o_regulator_enable, .o_core_powered, .o_conversion_mode, .o_command_cycle_select, .o_status_append,
    .o_alert_mode, .o_irq);
  link_host_model i_link_host_model (.o_link(i_link), .i_sdo(o_sdo));

  // System clock
  always #20 i_clk_sys = ~i_clk_sys;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Write: address and data offered together, bready held until the answer
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = setup_pkg::RESP_OKAY);
    logic aw, w, b;
    @(posedge i_clk_sys);
    {i_awaddr, i_wdata} <= {a, 24'h0, d};
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    {aw, w, b} = 3'h7;
    for (int n = 0; n < 64 && b; n++) begin
      @(posedge i_clk_sys);
      if (aw && o_awready) begin
        aw = 1'h0;
        i_awvalid <= 1'h0;
      end
      if (w && o_wready) begin
        w = 1'h0;
        i_wvalid <= 1'h0;
      end
      if (o_bvalid) begin
        b = 1'h0;
        i_bready <= 1'h0;
        chk(o_bresp, er);
      end
    end
    if (b) chk(1, 0);
  endtask

  // Read: rready held until rvalid is seen
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = setup_pkg::RESP_OKAY);
    logic r;
    @(posedge i_clk_sys);
    i_araddr <= a;
    {i_arvalid, i_rready} <= 2'h3;
    r = 1'h1;
    for (int n = 0; n < 64 && r; n++) begin
      @(posedge i_clk_sys);
      if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      if (o_rvalid) begin
        r = 1'h0;
        i_rready <= 1'h0;
        chk(o_rdata, ed);
        chk(o_rresp, er);
      end
    end
    if (r) chk(1, 0);
  endtask

  // One conversion result with its threshold qualifiers
  task automatic pulse(input logic [2:0] c, input logic u, input logic l, input logic h);
    @(posedge i_clk_sys);
    {i_result_valid, i_result_chan, i_above_upper, i_below_lower, i_within_hyst} <= {1'h1, c, u, l, h};
    @(posedge i_clk_sys);
    {i_result_valid, i_above_upper, i_below_lower, i_within_hyst} <= 4'h0;
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, several times the expected run
  initial begin
    #200000;
    n_fail++;
    final_report;
  end

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    axr(setup_pkg::ADDR_SETUP, 32'h10);
    for (int b = 0; b < 8; b++) begin
      v = 8'h01 << b;
      axw(setup_pkg::ADDR_SETUP, v);
      axr(setup_pkg::ADDR_SETUP, {24'h0, v});
      chk({o_alert_mode, o_status_append, o_regulator_enable, o_conversion_mode, o_command_cycle_select,
        o_core_powered}, {v[7], v[5], v[4], v[2], v[1], 1'h1});
    end
    // Masked-off byte lane and an unmapped place
    i_wstrb <= 4'hE;
    axw(setup_pkg::ADDR_SETUP, 8'hFF);
    axr(setup_pkg::ADDR_SETUP, 32'h80);
    i_wstrb <= 4'hF;
    axw(8'h40, 8'h55, setup_pkg::RESP_SLVERR);
    axr(8'h40, 32'h0, setup_pkg::RESP_SLVERR);
    $display("register test done");
    pulse(3'h3, 1'h1, 1'h0, 1'h0);
    chk(o_irq, 0);
    axw(setup_pkg::ADDR_IRQ_MASK, 8'h01);
    chk(o_irq, 1);
    axr(setup_pkg::ADDR_ALERT, 32'h0800);
    axr(setup_pkg::ADDR_ALERT, 32'h0);
    axw(setup_pkg::ADDR_IRQ_STAT, 8'h01);
    chk(o_irq, 0);
    for (int k = 0; k < 2; k++) begin
      axw(setup_pkg::ADDR_SETUP, {k[0], 7'h10});
      pulse(3'h2, 1'h0, 1'h1, 1'h0);
      pulse(3'h2, 1'h0, 1'h0, 1'h1);
      axr(setup_pkg::ADDR_ALERT, k ? 32'h4 : 32'h0);
    end
    $display("alert test done");
    pulse(3'h5, 1'h1, 1'h0, 1'h0);
    // command cycle bit kept low while frames run
    axw(setup_pkg::ADDR_SETUP, 8'h34);
    i_link_host_model.frame(20, 5'h00, got, pre, post);
    chk(got, 20'hA5C3B);
    chk(post, 1);
    repeat (20) @(posedge i_clk_sys);
    chk(o_sdo, 1);
    i_result_data <= 16'h5A3C;
    i_conv_busy <= 1'h1;
    axw(setup_pkg::ADDR_SETUP, 8'h54);
    i_link_host_model.frame(16, setup_pkg::CMD_REG_MODE, got, pre, post);
    chk({pre, got[15:0], post}, {1'h1, 16'h5A3C, 1'h1});
    axr(setup_pkg::ADDR_SETUP, 32'h50);
    axr(setup_pkg::ADDR_IRQ_STAT, 32'h7);
    $display("link test done");
    i_ext_core_supply <= 1'h0;
    axw(setup_pkg::ADDR_SETUP, 8'h00);
    repeat (3) @(posedge i_clk_sys);
    chk(o_core_powered, 0);
    axw(setup_pkg::ADDR_SETUP, 8'h14);
    axr(setup_pkg::ADDR_SETUP, 32'h0);
    axr(setup_pkg::ADDR_LINK_STAT, 32'h13);
    $display("power test done");
    final_report;
  end
endmodule
